/* File: core/cgoc_top.sv */
// module: clock gating, key-protected oscillator enables and control over AXI4-Lite
module cgoc_top
	import cgoc_pkg::*;
#(
	parameter int unsigned NOSC = CGOC_NOSC
) (
	input  wire logic                   CLK,
	input  wire logic                   RESETN,
	input  wire logic [CGOC_ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic [2:0]             S_AXI_AWPROT,
	input  wire logic                   S_AXI_AWVALID,
	output logic                        S_AXI_AWREADY,
	input  wire logic [CGOC_DATA_W-1:0] S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output logic                        S_AXI_WREADY,
	output logic [1:0]                  S_AXI_BRESP,
	output logic                        S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [CGOC_ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic [2:0]             S_AXI_ARPROT,
	input  wire logic                   S_AXI_ARVALID,
	output logic                        S_AXI_ARREADY,
	output logic [CGOC_DATA_W-1:0]      S_AXI_RDATA,
	output logic [1:0]                  S_AXI_RRESP,
	output logic                        S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY,
	input  wire logic [NOSC-1:0]        OSC_READY_ASYNC,
	output logic                        CHOP_CLK_OFF,
	output logic                        SLEEP_TIMER_CLK_OFF,
	output logic                        FRONTEND_CTRL_CLK_OFF,
	output logic [CGOC_GATE_W-1:0]      CLK_GATE_ENABLE,
	output logic                        SLOW_OSC_ENABLE,
	output logic                        FAST_OSC_ENABLE,
	output logic                        CRYSTAL_ENABLE,
	output logic                        IRQ
);

	function automatic cgoc_sel_t cgoc_decode(input logic [CGOC_ADDR_W-1:0] addr);
		cgoc_sel_t sel;
		case (addr)
			CGOC_GATE_OFS: sel = CGOC_SEL_GATE;
			CGOC_KEY_OFS:  sel = CGOC_SEL_KEY;
			CGOC_OSC_OFS:  sel = CGOC_SEL_OSC;
			CGOC_CHOP_OFS: sel = CGOC_SEL_CHOP;
			CGOC_STAT_OFS: sel = CGOC_SEL_STAT;
			CGOC_MASK_OFS: sel = CGOC_SEL_MASK;
			default:       sel = CGOC_SEL_NONE;
		endcase
		return sel;
	endfunction : cgoc_decode

	// merge write data into a 16-bit register under the two low byte strobes
	function automatic logic [CGOC_REG_W-1:0] cgoc_merge(
		input logic [CGOC_REG_W-1:0] old,
		input logic [CGOC_DATA_W-1:0] data,
		input logic [3:0]             strb
	);
		logic [CGOC_REG_W-1:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction : cgoc_merge

	logic                   aw_full_r;
	logic                   w_full_r;
	logic                   ar_full_r;
	logic [CGOC_ADDR_W-1:0] wr_addr_r;
	logic [CGOC_DATA_W-1:0] wr_data_r;
	logic [3:0]             wr_strb_r;
	logic [CGOC_ADDR_W-1:0] rd_addr_r;
	logic                   awready_r;
	logic                   wready_r;
	logic                   arready_r;
	logic                   bvalid_r;
	logic [1:0]             bresp_r;
	logic                   rvalid_r;
	logic [1:0]             rresp_r;
	logic [CGOC_DATA_W-1:0] rdata_r;

	logic [CGOC_CHOP_W-1:0] chop_r;
	logic [CGOC_GATE_W-1:0] gate_r;
	logic [CGOC_REG_W-1:0]  key_r;
	logic                   unlocked_r;
	logic [NOSC-1:0]        osc_en_r;
	logic [CGOC_NEVT-1:0]   status_r;
	logic [CGOC_NEVT-1:0]   mask_r;
	logic                   irq_r;

	logic                   aw_hs;
	logic                   w_hs;
	logic                   ar_hs;
	logic                   do_write;
	logic                   do_read;
	logic                   aw_full_nxt;
	logic                   w_full_nxt;
	logic                   ar_full_nxt;
	cgoc_sel_t              wr_sel;
	cgoc_sel_t              rd_sel;
	logic [CGOC_REG_W-1:0]  wr_val;
	logic                   key_match;
	logic                   osc_reject;
	logic [NOSC-1:0]        osc_stable;
	logic [NOSC-1:0]        osc_settled;
	logic [CGOC_NEVT-1:0]   events;
	logic [CGOC_NEVT-1:0]   status_nxt;
	logic [CGOC_REG_W-1:0]  rd_val;
	logic [CGOC_REG_W-1:0]  chop_mrg;
	logic [CGOC_REG_W-1:0]  gate_mrg;
	logic [CGOC_REG_W-1:0]  mask_mrg;
	logic [CGOC_REG_W-1:0]  osc_mrg;

	assign aw_hs       = S_AXI_AWVALID & awready_r;
	assign w_hs        = S_AXI_WVALID & wready_r;
	assign ar_hs       = S_AXI_ARVALID & arready_r;
	assign do_write    = aw_full_r & w_full_r & ~bvalid_r;
	assign do_read     = ar_full_r & ~rvalid_r;
	assign aw_full_nxt = (aw_full_r & ~do_write) | aw_hs;
	assign w_full_nxt  = (w_full_r & ~do_write) | w_hs;
	assign ar_full_nxt = (ar_full_r & ~do_read) | ar_hs;
	assign wr_sel      = cgoc_decode(wr_addr_r);
	assign rd_sel      = cgoc_decode(rd_addr_r);
	assign wr_val      = cgoc_merge(CGOC_REG_W'(0), wr_data_r, wr_strb_r);
	// merged words are formed apart, a function result cannot be sliced in place
	assign chop_mrg    = cgoc_merge(CGOC_REG_W'(chop_r), wr_data_r, wr_strb_r);
	assign gate_mrg    = cgoc_merge(CGOC_REG_W'(gate_r), wr_data_r, wr_strb_r);
	assign mask_mrg    = cgoc_merge(CGOC_REG_W'(mask_r), wr_data_r, wr_strb_r);
	assign osc_mrg     = cgoc_merge(CGOC_REG_W'(osc_en_r), wr_data_r, wr_strb_r);
	// a partial key write can never unlock
	assign key_match   = (wr_strb_r[1:0] == 2'b11) && (wr_val == CGOC_UNLOCK_KEY);
	assign osc_reject  = do_write && (wr_sel == CGOC_SEL_OSC) && !unlocked_r;

	// write address and data are held independently, so either may come first
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
			wr_strb_r <= '0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awready_r <= ~aw_full_nxt;
			wready_r  <= ~w_full_nxt;
			if (aw_hs) begin
				wr_addr_r <= {S_AXI_AWADDR[CGOC_ADDR_W-1:2], 2'b00};
			end
			if (w_hs) begin
				wr_data_r <= S_AXI_WDATA;
				wr_strb_r <= S_AXI_WSTRB;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			bvalid_r <= 1'b0;
			bresp_r  <= CGOC_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wr_sel == CGOC_SEL_NONE) ? CGOC_RESP_SLVERR : CGOC_RESP_OKAY;
		end else if (S_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			chop_r <= CGOC_CHOP_RST;
			gate_r <= CGOC_GATE_RST;
			key_r  <= CGOC_KEY_RST;
			mask_r <= CGOC_EVT_RST;
		end else if (do_write) begin
			case (wr_sel)
				CGOC_SEL_CHOP: chop_r <= chop_mrg[CGOC_CHOP_W-1:0];
				CGOC_SEL_GATE: gate_r <= gate_mrg[CGOC_GATE_W-1:0];
				CGOC_SEL_KEY:  key_r  <= cgoc_merge(key_r, wr_data_r, wr_strb_r);
				CGOC_SEL_MASK: mask_r <= mask_mrg[CGOC_NEVT-1:0];
				default: begin
				end
			endcase
		end
	end

	// the lock opens for exactly one following write; any write, even unmapped, closes it
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			unlocked_r <= 1'b0;
		end else if (do_write) begin
			unlocked_r <= (wr_sel == CGOC_SEL_KEY) && key_match;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			osc_en_r <= NOSC'(CGOC_OSC_EN_RST);
		end else if (do_write && (wr_sel == CGOC_SEL_OSC) && unlocked_r) begin
			osc_en_r <= osc_mrg[CGOC_EN_LSB +: NOSC];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NOSC; gi++) begin : g_osc
			cgoc_settle u_settle (
				.clk          (CLK),
				.resetn       (RESETN),
				.enable       (osc_en_r[gi]),
				.ready_async  (OSC_READY_ASYNC[gi]),
				.stable       (osc_stable[gi]),
				.settle_pulse (osc_settled[gi])
			);
		end
	endgenerate

	// a new event in the clearing cycle survives the clear
	always_comb begin
		events = '0;
		events[NOSC-1:0] = osc_settled;
		events[CGOC_EVT_REJECT] = osc_reject;
		status_nxt = status_r;
		if (do_write && (wr_sel == CGOC_SEL_STAT)) begin
			status_nxt = status_r & ~wr_val[CGOC_NEVT-1:0];
		end
		status_nxt = status_nxt | events;
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			status_r <= CGOC_EVT_RST;
			irq_r    <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r    <= |(status_nxt & mask_r);
		end
	end

	always_comb begin
		rd_val = '0;
		case (rd_sel)
			CGOC_SEL_CHOP: rd_val[CGOC_CHOP_W-1:0] = chop_r;
			CGOC_SEL_GATE: rd_val[CGOC_GATE_W-1:0] = gate_r;
			CGOC_SEL_KEY:  rd_val = key_r;
			CGOC_SEL_OSC: begin
				rd_val[CGOC_EN_LSB +: NOSC]     = osc_en_r;
				rd_val[CGOC_STABLE_LSB +: NOSC] = osc_stable;
			end
			CGOC_SEL_STAT: rd_val[CGOC_NEVT-1:0] = status_r;
			CGOC_SEL_MASK: rd_val[CGOC_NEVT-1:0] = mask_r;
			default:       rd_val = '0;
		endcase
	end

	// reads never touch the lock, so polling does not break a key sequence
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ar_full_r <= 1'b0;
			arready_r <= 1'b0;
			rd_addr_r <= '0;
		end else begin
			ar_full_r <= ar_full_nxt;
			arready_r <= ~ar_full_nxt;
			if (ar_hs) begin
				rd_addr_r <= {S_AXI_ARADDR[CGOC_ADDR_W-1:2], 2'b00};
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			rvalid_r <= 1'b0;
			rresp_r  <= CGOC_RESP_OKAY;
			rdata_r  <= '0;
		end else if (do_read) begin
			rvalid_r <= 1'b1;
			rresp_r  <= (rd_sel == CGOC_SEL_NONE) ? CGOC_RESP_SLVERR : CGOC_RESP_OKAY;
			rdata_r  <= CGOC_DATA_W'(rd_val);
		end else if (S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	assign S_AXI_AWREADY         = awready_r;
	assign S_AXI_WREADY          = wready_r;
	assign S_AXI_BVALID          = bvalid_r;
	assign S_AXI_BRESP           = bresp_r;
	assign S_AXI_ARREADY         = arready_r;
	assign S_AXI_RVALID          = rvalid_r;
	assign S_AXI_RRESP           = rresp_r;
	assign S_AXI_RDATA           = rdata_r;
	assign CHOP_CLK_OFF          = chop_r[CGOC_CHOP_OFF_BIT];
	assign SLEEP_TIMER_CLK_OFF   = chop_r[CGOC_SLEEP_OFF_BIT];
	assign FRONTEND_CTRL_CLK_OFF = gate_r[CGOC_FRONT_OFF_BIT];
	assign CLK_GATE_ENABLE       = gate_r;
	assign SLOW_OSC_ENABLE       = osc_en_r[0];
	assign FAST_OSC_ENABLE       = osc_en_r[1];
	assign CRYSTAL_ENABLE        = osc_en_r[2];
	assign IRQ                   = irq_r;

endmodule : cgoc_top

/* File: pkg/cgoc_pkg.sv */
// package: register map, field positions, reset values and encodings of the clock gate block
package cgoc_pkg;

	localparam int unsigned CGOC_ADDR_W = 12;
	localparam int unsigned CGOC_DATA_W = 32;
	localparam int unsigned CGOC_REG_W  = 16;
	localparam int unsigned CGOC_NOSC   = 3;
	localparam int unsigned CGOC_NEVT   = 4;

	// byte addresses
	localparam logic [11:0] CGOC_GATE_OFS = 12'h0410;
	localparam logic [11:0] CGOC_KEY_OFS  = 12'h0a0c;
	localparam logic [11:0] CGOC_OSC_OFS  = 12'h0a10;
	localparam logic [11:0] CGOC_CHOP_OFS = 12'h0a70;
	localparam logic [11:0] CGOC_STAT_OFS = 12'h0a80;
	localparam logic [11:0] CGOC_MASK_OFS = 12'h0a84;

	// chop_and_timer_clock_disable fields
	localparam int unsigned CGOC_CHOP_OFF_BIT  = 2;
	localparam int unsigned CGOC_SLEEP_OFF_BIT = 1;
	localparam int unsigned CGOC_CHOP_W        = 3;
	localparam logic [2:0]  CGOC_CHOP_RST      = 3'h4;

	// clock_gate_enable fields
	localparam int unsigned CGOC_FRONT_OFF_BIT = 5;
	localparam int unsigned CGOC_GATE_W        = 10;
	localparam logic [9:0]  CGOC_GATE_RST      = 10'h01c0;

	// oscillator_unlock_key
	localparam logic [15:0] CGOC_KEY_RST    = 16'h0000;
	localparam logic [15:0] CGOC_UNLOCK_KEY = 16'hcb14;

	// oscillator_control fields
	localparam int unsigned CGOC_EN_LSB     = 0;
	localparam int unsigned CGOC_STABLE_LSB = 8;
	localparam logic [2:0]  CGOC_OSC_EN_RST = 3'h3;

	// event status bits: 2..0 oscillator settled, 3 locked write dropped
	localparam int unsigned CGOC_EVT_REJECT = 3;
	localparam logic [3:0]  CGOC_EVT_RST    = 4'h0;

	localparam logic [1:0] CGOC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CGOC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CGOC_SEL_NONE,
		CGOC_SEL_GATE,
		CGOC_SEL_KEY,
		CGOC_SEL_OSC,
		CGOC_SEL_CHOP,
		CGOC_SEL_STAT,
		CGOC_SEL_MASK
	} cgoc_sel_t;

endpackage : cgoc_pkg

/* File: core/cgoc_settle.sv */
// module: oscillator ready synchroniser and one-shot settle flag
module cgoc_settle (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic enable,
	input  wire logic ready_async,
	output logic      stable,
	output logic      settle_pulse
);

	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic ready_r;
	logic stable_r;
	logic pulse_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= ready_async;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// a change is taken only when the last two stages agree
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ready_r <= 1'b0;
		end else if (sync2_r == sync3_r) begin
			ready_r <= sync3_r;
		end
	end

	// flag latches on first settle and ignores later loss while enabled
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stable_r <= 1'b0;
			pulse_r  <= 1'b0;
		end else if (!enable) begin
			stable_r <= 1'b0;
			pulse_r  <= 1'b0;
		end else begin
			if (ready_r) begin
				stable_r <= 1'b1;
			end
			pulse_r <= ready_r & ~stable_r;
		end
	end

	assign stable       = stable_r;
	assign settle_pulse = pulse_r;

endmodule : cgoc_settle

/* File: verif/cgoc_checker.sv */
// checker: bus timing, reset values and register-to-pin relations of the clock gate block
module cgoc_checker
	import cgoc_pkg::*;
(
	input wire logic                   CLK,
	input wire logic                   RESETN,
	input wire logic                   S_AXI_AWVALID,
	input wire logic                   S_AXI_AWREADY,
	input wire logic                   S_AXI_WVALID,
	input wire logic                   S_AXI_WREADY,
	input wire logic                   S_AXI_BVALID,
	input wire logic                   S_AXI_BREADY,
	input wire logic [1:0]             S_AXI_BRESP,
	input wire logic                   S_AXI_ARVALID,
	input wire logic                   S_AXI_ARREADY,
	input wire logic                   S_AXI_RVALID,
	input wire logic                   S_AXI_RREADY,
	input wire logic [CGOC_DATA_W-1:0] S_AXI_RDATA,
	input wire logic                   CHOP_CLK_OFF,
	input wire logic                   SLEEP_TIMER_CLK_OFF,
	input wire logic                   FRONTEND_CTRL_CLK_OFF,
	input wire logic [CGOC_GATE_W-1:0] CLK_GATE_ENABLE,
	input wire logic                   SLOW_OSC_ENABLE,
	input wire logic                   FAST_OSC_ENABLE,
	input wire logic                   CRYSTAL_ENABLE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	sequence wr_take;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID;
	endsequence
	sequence wr_answer;
		!S_AXI_AWREADY ##1 S_AXI_BVALID;
	endsequence
	sequence rd_take;
		S_AXI_ARVALID && S_AXI_ARREADY && !S_AXI_RVALID;
	endsequence
	sequence rd_answer;
		!S_AXI_ARREADY ##1 S_AXI_RVALID;
	endsequence

	AST_WR_LAT:
		assert property (wr_take |=> wr_answer) else $error("write answer off time");
	AST_RD_LAT:
		assert property (rd_take |=> rd_answer) else $error("read answer off time");
	AST_B_HOLD:
		assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	AST_R_HOLD:
		assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
	AST_CHOP_RST:
		assert property ($rose(RESETN) |-> CHOP_CLK_OFF) else $error("chop clock runs after reset");
	AST_SLEEP_RST:
		assert property ($rose(RESETN) |-> !SLEEP_TIMER_CLK_OFF) else $error("timer clock off");
	AST_FRONT_EQ:
		assert property (FRONTEND_CTRL_CLK_OFF == CLK_GATE_ENABLE[5]) else $error("front gate mismatch");
	AST_OSC_RST:
		assert property ($rose(RESETN) |-> {CRYSTAL_ENABLE, FAST_OSC_ENABLE, SLOW_OSC_ENABLE} == 3'h3)
		else $error("oscillator enables wrong after reset");
	// enables may only move with a completed bus write, never on their own
	AST_OSC_KEYED:
		assert property ($changed({CRYSTAL_ENABLE, FAST_OSC_ENABLE, SLOW_OSC_ENABLE})
			|-> $rose(S_AXI_BVALID)) else $error("enables changed without a write");
	AST_RDATA_HI:
		assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000) else $error("upper data set");
endmodule : cgoc_checker

bind cgoc_top cgoc_checker u_chk (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .CHOP_CLK_OFF(CHOP_CLK_OFF),
	.SLEEP_TIMER_CLK_OFF(SLEEP_TIMER_CLK_OFF), .FRONTEND_CTRL_CLK_OFF(FRONTEND_CTRL_CLK_OFF),
	.CLK_GATE_ENABLE(CLK_GATE_ENABLE), .SLOW_OSC_ENABLE(SLOW_OSC_ENABLE),
	.FAST_OSC_ENABLE(FAST_OSC_ENABLE), .CRYSTAL_ENABLE(CRYSTAL_ENABLE));

/* File: verif/cgoc_bench.sv */
// testbench: register access, key lock, clock gates, settle flags and interrupt of the block
module cgoc_bench
	import cgoc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, awv, wv, br, arv, rr, awr, wrr, bv, arr, rv;
	logic        chop, slp, fro, slo, fst, cry, irq;
	logic [11:0] aw, ar;
	logic [31:0] wd, rdat, v;
	logic [1:0]  bresp, rresp, rsp;
	logic [9:0]  gate;
	logic [2:0]  rdy;
	logic [3:0]  strb;
	int          num_errors, total_checks, cyc;

	cgoc_top dut (.CLK(clk), .RESETN(rstn), .S_AXI_AWADDR(aw), .S_AXI_AWPROT(3'h0),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rr), .OSC_READY_ASYNC(rdy), .CHOP_CLK_OFF(chop), .SLEEP_TIMER_CLK_OFF(slp),
		.FRONTEND_CTRL_CLK_OFF(fro), .CLK_GATE_ENABLE(gate), .SLOW_OSC_ENABLE(slo),
		.FAST_OSC_ENABLE(fst), .CRYSTAL_ENABLE(cry), .IRQ(irq));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic complete_run;
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// ceiling well above the roughly 150 cycles the scenarios need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// handshakes are judged at the falling edge, where registered readies have settled
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		logic ta, tw, tb;
		@(posedge clk);
		aw <= a;
		wd <= d;
		strb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wrr;
			tb = bv;
			rsp = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		br <= 1'b0;
		// outputs launched by the answering edge are judged once they have settled
		@(negedge clk);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic ta, tb;
		@(posedge clk);
		ar <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = arv && arr;
			tb = rv;
			d = rdat;
			rsp = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end
		rr <= 1'b0;
	endtask : rd

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		rd(a, x);
		chk(x, e);
	endtask : rchk

	task automatic t_reset;
		chk(chop, 1'h1);
		chk(slp, 1'h0);
		chk(fro, 1'h0);
		chk({cry, fst, slo}, 3'h3);
		chk(irq, 1'h0);
		rchk(CGOC_GATE_OFS, 32'h0000_01c0);
		rchk(CGOC_OSC_OFS, 32'h0000_0003);
		rchk(CGOC_CHOP_OFS, 32'h0000_0004);
		rchk(CGOC_KEY_OFS, 32'h0000_0000);
		chk(rsp, CGOC_RESP_OKAY);
	endtask : t_reset

	task automatic t_gate;
		wr(CGOC_GATE_OFS, 32'h0000_01e9);
		chk(gate, 10'h1e9);
		chk(fro, 1'h1);
		chk(rsp, CGOC_RESP_OKAY);
		wr(CGOC_GATE_OFS, 32'hffff_01c9);
		chk(fro, 1'h0);
		rchk(CGOC_GATE_OFS, 32'h0000_01c9);
		wr(CGOC_CHOP_OFS, 32'h0000_0002);
		chk({chop, slp}, 2'h1);
		wr(CGOC_CHOP_OFS, 32'h0000_0004);
		chk({chop, slp}, 2'h2);
		rd(12'h0ff, v);
		chk(rsp, CGOC_RESP_SLVERR);
		chk(v, 32'h0000_0000);
		wr(12'h0ff, 32'h0000_ffff);
		chk(rsp, CGOC_RESP_SLVERR);
	endtask : t_gate

	task automatic t_lock;
		wr(CGOC_OSC_OFS, 32'h0000_0007);
		chk(cry, 1'h0);
		chk(rsp, CGOC_RESP_OKAY);
		chk(irq, 1'h0);
		wr(CGOC_MASK_OFS, 32'h0000_0008);
		chk(irq, 1'h1);
		wr(CGOC_STAT_OFS, 32'h0000_0008);
		chk(irq, 1'h0);
		wr(CGOC_KEY_OFS, 32'h0000_cb14);
		wr(CGOC_GATE_OFS, 32'h0000_01c9);
		wr(CGOC_OSC_OFS, 32'h0000_0007);
		chk(cry, 1'h0);
		wr(CGOC_KEY_OFS, 32'h0000_1234);
		wr(CGOC_OSC_OFS, 32'h0000_0007);
		chk(cry, 1'h0);
		wr(CGOC_KEY_OFS, 32'h0000_cb14, 4'h1);
		wr(CGOC_OSC_OFS, 32'h0000_0007);
		chk(cry, 1'h0);
		wr(CGOC_KEY_OFS, 32'h0000_cb14);
		wr(CGOC_OSC_OFS, 32'h0000_0007);
		chk(cry, 1'h1);
		rchk(CGOC_OSC_OFS, 32'h0000_0007);
	endtask : t_lock

	task automatic t_flags;
		int i;
		wr(CGOC_STAT_OFS, 32'h0000_000f);
		wr(CGOC_MASK_OFS, 32'h0000_0007);
		@(posedge clk);
		rdy <= 3'h7;
		for (i = 0; i < 40 && irq !== 1'b1; i++)
			@(negedge clk);
		chk(irq, 1'h1);
		rchk(CGOC_OSC_OFS, 32'h0000_0707);
		rchk(CGOC_STAT_OFS, 32'h0000_0007);
		@(posedge clk);
		rdy <= 3'h3;
		repeat (8) @(posedge clk);
		rchk(CGOC_OSC_OFS, 32'h0000_0707);
		wr(CGOC_KEY_OFS, 32'h0000_cb14);
		wr(CGOC_OSC_OFS, 32'h0000_0005);
		chk(fst, 1'h0);
		rchk(CGOC_OSC_OFS, 32'h0000_0505);
	endtask : t_flags

	initial begin
		{rstn, awv, wv, br, arv, rr, aw, ar, wd, rdy, strb} = '0;
		num_errors = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_gate();
		t_lock();
		t_flags();
		complete_run();
	end
endmodule : cgoc_bench
